// ===== rtl/pmgpi_top.sv
// Port multiplexer with GPIO and four pin interrupt channels.
// Assumes pad_in comes from the pads (asynchronous), peripheral signals
// and control strobes come from ref_clk logic.

`timescale 1ns/1ps
`default_nettype none

module pmgpi_top
   import pmgpi_pkg::*;
(
   input  wire logic                                               ref_clk,
   input  wire logic                                               nrst,
   input  wire pmgpi_port_wr_s [NUM_PORTS-1:0]                     port_wr,
   input  wire logic [NUM_PORTS-1:0][PORT_PINS-1:0][NUM_FUNC-1:0]  periph_o,
   input  wire logic [NUM_PORTS-1:0][PORT_PINS-1:0][NUM_FUNC-1:0]  periph_oe,
   input  wire logic [NUM_PORTS-1:0][PORT_PINS-1:0]                pad_in,
   input  wire pmgpi_chan_wr_s [NUM_CHAN-1:0]                      chan_wr,
   output var  logic [NUM_PORTS-1:0][PORT_PINS-1:0]                pad_out_q,
   output var  logic [NUM_PORTS-1:0][PORT_PINS-1:0]                pad_oe_n_q,
   output var  logic [NUM_PORTS-1:0][PORT_PINS-1:0]                periph_in_q,
   output var  logic [NUM_PORTS-1:0][PORT_PINS-1:0]                gpio_fn_q,
   output var  logic [NUM_PORTS-1:0][PORT_PINS-1:0]                gpio_dir_q,
   output var  logic [NUM_PORTS-1:0][PORT_PINS-1:0]                gpio_data_q,
   output var  logic [NUM_PORTS-1:0][PORT_PINS-1:0]                gpio_inen_q,
   output var  logic [NUM_PORTS-1:0][PORT_PINS-1:0]                gpio_pin_q,
   output var  logic [NUM_PORTS-1:0][MUX_W-1:0]                    gpio_mux_q,
   output var  pmgpi_chan_st_s [NUM_CHAN-1:0]                      chan_st_q,
   output var  logic                                               pin_irq_channel_0,
   output var  logic                                               pin_irq_channel_1,
   output var  logic                                               pin_irq_channel_2,
   output var  logic                                               pin_irq_channel_3
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------

   // All port state in one record so reset and update stay in step.
   typedef struct packed {
      logic [NUM_PORTS-1:0][PORT_PINS-1:0] fn;
      logic [NUM_PORTS-1:0][PORT_PINS-1:0] dir;
      logic [NUM_PORTS-1:0][PORT_PINS-1:0] data;
      logic [NUM_PORTS-1:0][PORT_PINS-1:0] inen;
      logic [NUM_PORTS-1:0][MUX_W-1:0]     mux;
      logic [NUM_PORTS-1:0][PORT_PINS-1:0] sync1;
      logic [NUM_PORTS-1:0][PORT_PINS-1:0] sync2;
      logic [NUM_PORTS-1:0][PORT_PINS-1:0] pad_out;
      logic [NUM_PORTS-1:0][PORT_PINS-1:0] pad_oe_n;
      logic [NUM_PORTS-1:0][PORT_PINS-1:0] periph_in;
      logic [NUM_PORTS-1:0][PORT_PINS-1:0] pin_rd;
   } pmgpi_top_s;

   pmgpi_top_s s_q;
   pmgpi_top_s s_d;

   logic [NUM_CHAN-1:0] chan_irq;

   // ----------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------

   // Returns the two-bit function select of one pin from a port's mux
   // word; used for both the output value and the output enable.
   function automatic logic [FSEL_W-1:0] fsel(input logic [MUX_W-1:0] word,
                                              input int                pin);
      logic [FSEL_W-1:0] r;
      r = word[pin*FSEL_W +: FSEL_W];
      return r;
   endfunction : fsel

   // Applies set and clear strobes to a control word; the set term
   // wins when both hit the same bit, and absent pins read zero.
   function automatic logic [PORT_PINS-1:0] setclr(input logic [PORT_PINS-1:0] cur,
                                                   input logic [PORT_PINS-1:0] set,
                                                   input logic [PORT_PINS-1:0] clr,
                                                   input logic [PORT_PINS-1:0] present);
      logic [PORT_PINS-1:0] r;
      r = ((cur & ~clr) | set) & present;
      return r;
   endfunction : setclr

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------

   // Control words, pin synchronisers and pad drive for every port.
   // The pad drive is computed from the registered controls, so a
   // control write reaches the pad two edges after the strobe; this
   // keeps every pad output on a flop at the cost of one cycle.
   always_comb begin
      s_d = s_q;
      for (int p = 0; p < NUM_PORTS; p++) begin
         // Each port has its own controls and pin count.
         s_d.fn[p]   = setclr(s_q.fn[p], port_wr[p].fn_set,
                              port_wr[p].fn_clr, PIN_PRESENT[p]);
         s_d.dir[p]  = setclr(s_q.dir[p], port_wr[p].dir_set,
                              port_wr[p].dir_clr, PIN_PRESENT[p]);
         s_d.data[p] = setclr(s_q.data[p], port_wr[p].data_set,
                              port_wr[p].data_clr, PIN_PRESENT[p]);
         s_d.inen[p] = setclr(s_q.inen[p], port_wr[p].inen_set,
                              port_wr[p].inen_clr, PIN_PRESENT[p]);
         if (port_wr[p].mux_wr) begin
            s_d.mux[p] = port_wr[p].mux_data;
         end

         // Two-flop synchroniser; only sync2 is read by any logic.
         s_d.sync1[p] = pad_in[p];
         s_d.sync2[p] = s_q.sync1[p];

         for (int i = 0; i < PORT_PINS; i++) begin
            if (s_q.fn[p][i]) begin
               // Peripheral owns the pin through its selected function.
               s_d.pad_out[p][i]   = periph_o[p][i][fsel(s_q.mux[p], i)];
               s_d.pad_oe_n[p][i]  = ~periph_oe[p][i][fsel(s_q.mux[p], i)];
               s_d.periph_in[p][i] = s_q.sync2[p][i];
               s_d.pin_rd[p][i]    = 1'b0;
            end else begin
               // GPIO: each pin stands alone, driver and buffer gated.
               s_d.pad_out[p][i]   = s_q.data[p][i] & s_q.dir[p][i];
               s_d.pad_oe_n[p][i]  = ~(s_q.dir[p][i] & PIN_PRESENT[p][i]);
               s_d.periph_in[p][i] = 1'b0;
               s_d.pin_rd[p][i]    = s_q.sync2[p][i] & s_q.inen[p][i];
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------

   // Reset puts every pin in GPIO mode with driver and buffer off.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         s_q          <= '0;
         s_q.fn       <= {NUM_PORTS{RST_FN}};
         s_q.dir      <= {NUM_PORTS{RST_DIR}};
         s_q.data     <= {NUM_PORTS{RST_DATA}};
         s_q.inen     <= {NUM_PORTS{RST_INEN}};
         s_q.mux      <= {NUM_PORTS{RST_MUX}};
         s_q.pad_oe_n <= '1;
      end else begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // Interrupt channels
   // ----------------------------------------------------------------

   // Channels watch the synchronised pads directly, so detection does
   // not care about function, direction or input enable.
   for (genvar c = 0; c < NUM_CHAN; c++) begin : g_chan
      pmgpi_irq_chan u_chan (
         .ref_clk (ref_clk),
         .nrst    (nrst),
         .pins_i  (s_q.sync2),
         .wr_i    (chan_wr[c]),
         .st_q    (chan_st_q[c]),
         .irq_q   (chan_irq[c])
      );
   end

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------

   // Every output below is a flop of this module or of a channel.
   assign pad_out_q   = s_q.pad_out;
   assign pad_oe_n_q  = s_q.pad_oe_n;
   assign periph_in_q = s_q.periph_in;
   assign gpio_fn_q   = s_q.fn;
   assign gpio_dir_q  = s_q.dir;
   assign gpio_data_q = s_q.data;
   assign gpio_inen_q = s_q.inen;
   assign gpio_pin_q  = s_q.pin_rd;
   assign gpio_mux_q  = s_q.mux;

   // One request line per channel.
   assign pin_irq_channel_0 = chan_irq[0];
   assign pin_irq_channel_1 = chan_irq[1];
   assign pin_irq_channel_2 = chan_irq[2];
   assign pin_irq_channel_3 = chan_irq[3];

endmodule : pmgpi_top

`default_nettype wire

// ===== rtl/pmgpi_pkg.sv
// Constants, reset values and carrier structs for the port mux, GPIO
// and pin interrupt block.
// Assumes one clock and one asynchronous active-low reset for all users.

package pmgpi_pkg;

   // ----------------------------------------------------------------
   // Sizes
   // ----------------------------------------------------------------
   localparam int NUM_PORTS  = 10;
   localparam int PORT_PINS  = 16;
   localparam int NUM_PINS   = NUM_PORTS * PORT_PINS;
   localparam int NUM_CHAN   = 4;
   localparam int CHAN_BITS  = 32;
   localparam int HALF_BITS  = 8;
   localparam int HALF_SLOTS = CHAN_BITS / HALF_BITS;
   localparam int NUM_HALF   = NUM_PINS / HALF_BITS;
   localparam int HALF_IDX_W = 5;
   localparam int NUM_FUNC   = 4;
   localparam int FSEL_W     = 2;
   localparam int MUX_W      = PORT_PINS * FSEL_W;

   // Pins that exist on each port; absent pins stay inert.
   localparam logic [NUM_PORTS-1:0][PORT_PINS-1:0] PIN_PRESENT = {NUM_PORTS{16'hFFFF}};

   // ----------------------------------------------------------------
   // Reset values and field masks
   // ----------------------------------------------------------------
   localparam logic [PORT_PINS-1:0] RST_FN     = 16'h0000;
   localparam logic [PORT_PINS-1:0] RST_DIR    = 16'h0000;
   localparam logic [PORT_PINS-1:0] RST_DATA   = 16'h0000;
   localparam logic [PORT_PINS-1:0] RST_INEN   = 16'h0000;
   localparam logic [MUX_W-1:0]     RST_MUX    = 32'h00000000;
   localparam logic [CHAN_BITS-1:0] RST_ASSIGN = 32'h00000000;
   localparam logic [CHAN_BITS-1:0] RST_MASK   = 32'h00000000;
   localparam logic [CHAN_BITS-1:0] RST_EDGE   = 32'h00000000;
   localparam logic [CHAN_BITS-1:0] RST_INV    = 32'h00000000;
   localparam logic [CHAN_BITS-1:0] ASSIGN_FLD = 32'h1F1F1F1F;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [PORT_PINS-1:0] fn_set;
      logic [PORT_PINS-1:0] fn_clr;
      logic [PORT_PINS-1:0] dir_set;
      logic [PORT_PINS-1:0] dir_clr;
      logic [PORT_PINS-1:0] data_set;
      logic [PORT_PINS-1:0] data_clr;
      logic [PORT_PINS-1:0] inen_set;
      logic [PORT_PINS-1:0] inen_clr;
      logic                 mux_wr;
      logic [MUX_W-1:0]     mux_data;
   } pmgpi_port_wr_s;

   typedef struct packed {
      logic                 assign_wr;
      logic [CHAN_BITS-1:0] assign_data;
      logic [CHAN_BITS-1:0] mask_set;
      logic [CHAN_BITS-1:0] mask_clr;
      logic [CHAN_BITS-1:0] edge_set;
      logic [CHAN_BITS-1:0] edge_clr;
      logic [CHAN_BITS-1:0] inv_set;
      logic [CHAN_BITS-1:0] inv_clr;
      logic [CHAN_BITS-1:0] latch_clr;
   } pmgpi_chan_wr_s;

   typedef struct packed {
      logic [CHAN_BITS-1:0] assign_sel;
      logic [CHAN_BITS-1:0] mask;
      logic [CHAN_BITS-1:0] edge_mode;
      logic [CHAN_BITS-1:0] inv;
      logic [CHAN_BITS-1:0] latch;
      logic [CHAN_BITS-1:0] pins;
   } pmgpi_chan_st_s;

endpackage : pmgpi_pkg

// ===== rtl/pmgpi_irq_chan.sv
// One pin interrupt channel: half-port assignment, polarity, edge or
// level detection, latches and mask.
// Assumes pins_i is already synchronised to ref_clk.

`timescale 1ns/1ps
`default_nettype none

module pmgpi_irq_chan
   import pmgpi_pkg::*;
(
   input  wire logic                  ref_clk,
   input  wire logic                  nrst,
   input  wire logic [NUM_PINS-1:0]   pins_i,
   input  wire pmgpi_chan_wr_s        wr_i,
   output var  pmgpi_chan_st_s        st_q,
   output var  logic                  irq_q
);

   typedef struct packed {
      pmgpi_chan_st_s       st;
      logic [CHAN_BITS-1:0] prev;
      logic                 irq;
   } pmgpi_chan_s;

   pmgpi_chan_s s_q;
   pmgpi_chan_s s_d;
   logic [CHAN_BITS-1:0] raw;
   logic [CHAN_BITS-1:0] act;
   logic [CHAN_BITS-1:0] held;

   // Picks one half port out of all pins; an index past the last half
   // port gives zeros rather than wrapping onto a real pin.
   function automatic logic [HALF_BITS-1:0] half_sel(input logic [NUM_PINS-1:0] p,
                                                     input logic [HALF_IDX_W-1:0] idx);
      logic [HALF_BITS-1:0] r;
      r = '0;
      for (int h = 0; h < NUM_HALF; h++) begin
         if (idx == HALF_IDX_W'(h)) begin
            r = p[h*HALF_BITS +: HALF_BITS];
         end
      end
      return r;
   endfunction : half_sel

   // Each byte of the assignment word routes one half port.
   for (genvar k = 0; k < HALF_SLOTS; k++) begin : g_slot
      assign raw[k*HALF_BITS +: HALF_BITS] =
         half_sel(pins_i, s_q.st.assign_sel[k*HALF_BITS +: HALF_IDX_W]);
   end

   // Polarity is applied before detection, so inverted edge means falling.
   assign act  = raw ^ s_q.st.inv;
   assign held = (s_q.st.latch & ~wr_i.latch_clr) | (act & ~s_q.prev);

   // Next state; a set strobe wins over a clear strobe in the same cycle.
   always_comb begin
      s_d = s_q;
      if (wr_i.assign_wr) begin
         s_d.st.assign_sel = wr_i.assign_data & ASSIGN_FLD;
      end
      s_d.st.mask      = (s_q.st.mask & ~wr_i.mask_clr) | wr_i.mask_set;
      s_d.st.edge_mode = (s_q.st.edge_mode & ~wr_i.edge_clr) | wr_i.edge_set;
      s_d.st.inv       = (s_q.st.inv & ~wr_i.inv_clr) | wr_i.inv_set;
      s_d.st.latch     = (s_q.st.edge_mode & held) | (~s_q.st.edge_mode & act);
      s_d.st.pins      = raw;
      s_d.prev         = act;
      s_d.irq          = |(s_q.st.latch & s_q.st.mask);
   end

   // State register.
   always_ff @(posedge ref_clk or negedge nrst) begin
      if (!nrst) begin
         s_q              <= '0;
         s_q.st.assign_sel <= RST_ASSIGN;
         s_q.st.mask      <= RST_MASK;
         s_q.st.edge_mode <= RST_EDGE;
         s_q.st.inv       <= RST_INV;
      end else begin
         s_q <= s_d;
      end
   end

   assign st_q  = s_q.st;
   assign irq_q = s_q.irq;

endmodule : pmgpi_irq_chan

`default_nettype wire

// ===== verification/pmgpi_board.sv
// Board-side model of the pads for the pin mux, GPIO and pin interrupt top.
// Assumes the bench sets the level that outside parts put on undriven pads.
`timescale 1ns/1ps
`default_nettype none
module pmgpi_board
   import pmgpi_pkg::*;
(
   input  wire logic [NUM_PORTS-1:0][PORT_PINS-1:0] pad_drv,
   input  wire logic [NUM_PORTS-1:0][PORT_PINS-1:0] pad_oe_n,
   input  wire logic [NUM_PORTS-1:0][PORT_PINS-1:0] ext_lvl,
   output wire logic [NUM_PORTS-1:0][PORT_PINS-1:0] pad_lvl
);
   // A pad the block drives shows its value; a released pad shows the outside level.
   assign pad_lvl = (pad_oe_n & ext_lvl) | (~pad_oe_n & pad_drv);
endmodule : pmgpi_board
`default_nettype wire

// ===== verification/pmgpi_asserts.sv
// Concurrent checks on port 0 and channel 0 of the pin mux and interrupt top.
// Assumes it is bound to pmgpi_top and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module pmgpi_asserts
   import pmgpi_pkg::*;
(
   input wire logic                                ref_clk,
   input wire logic                                nrst,
   input wire pmgpi_port_wr_s [NUM_PORTS-1:0]      port_wr,
   input wire pmgpi_chan_wr_s [NUM_CHAN-1:0]       chan_wr,
   input wire logic [NUM_PORTS-1:0][PORT_PINS-1:0] pad_oe_n_q,
   input wire logic [NUM_PORTS-1:0][PORT_PINS-1:0] gpio_fn_q,
   input wire logic [NUM_PORTS-1:0][PORT_PINS-1:0] gpio_dir_q,
   input wire logic [NUM_PORTS-1:0][PORT_PINS-1:0] gpio_data_q,
   input wire logic [NUM_PORTS-1:0][PORT_PINS-1:0] gpio_inen_q,
   input wire logic [NUM_PORTS-1:0][PORT_PINS-1:0] gpio_pin_q,
   input wire pmgpi_chan_st_s [NUM_CHAN-1:0]       chan_st_q,
   input wire logic                                pin_irq_channel_0
);
   // ----------------------------------------------------------------
   // Properties
   // ----------------------------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   // Polarity must hold still, or the expected level is ambiguous.
   sequence lvl_steady_s;
      !chan_st_q[0].edge_mode[0] && $stable(chan_st_q[0].inv[0]);
   endsequence
   sequence rise_s;
      chan_st_q[0].edge_mode[0] && !chan_st_q[0].inv[0] && !chan_wr[0].inv_set[0] && !chan_wr[0].edge_clr[0]
         && !chan_wr[0].latch_clr[0] && $rose(chan_st_q[0].pins[0]);
   endsequence
   irq_mask_gate_a: assert property (pin_irq_channel_0 == $past(|(chan_st_q[0].latch & chan_st_q[0].mask)))
      else $error("channel 0 request does not follow masked latches");
   dir_set_a: assert property (|port_wr[0].dir_set |=> (gpio_dir_q[0] & $past(port_wr[0].dir_set)) == $past(port_wr[0].dir_set))
      else $error("direction set strobe lost");
   dir_clr_a: assert property (|port_wr[0].dir_clr && !(|port_wr[0].dir_set) |=> !(|(gpio_dir_q[0] & $past(port_wr[0].dir_clr))))
      else $error("direction clear strobe lost");
   data_hold_a: assert property (!(|(port_wr[0].data_set | port_wr[0].data_clr)) |=> $stable(gpio_data_q[0]))
      else $error("data word changed without a strobe");
   oe_dir_a: assert property (!gpio_fn_q[0][8] |=> pad_oe_n_q[0][8] == !$past(gpio_dir_q[0][8]))
      else $error("pad enable does not follow direction");
   pin_gate_a: assert property (!gpio_inen_q[0][8] [*2] |-> !gpio_pin_q[0][8])
      else $error("input seen with buffer off");
   edge_hold_a: assert property (chan_st_q[0].edge_mode[0] && chan_st_q[0].latch[0] && !chan_wr[0].latch_clr[0]
      && !chan_wr[0].edge_clr[0] |=> chan_st_q[0].latch[0]) else $error("edge latch dropped without clear");
   edge_rise_a: assert property (rise_s |=> chan_st_q[0].latch[0])
      else $error("rising edge not latched");
   level_follow_a: assert property (lvl_steady_s [*2] |-> chan_st_q[0].latch[0] == (chan_st_q[0].pins[0] ^ chan_st_q[0].inv[0]))
      else $error("level request does not follow pin");
   mask_set_a: assert property (|chan_wr[0].mask_set |=> (chan_st_q[0].mask & $past(chan_wr[0].mask_set)) == $past(chan_wr[0].mask_set))
      else $error("mask set strobe lost");
endmodule : pmgpi_asserts
bind pmgpi_top pmgpi_asserts u_chk (.ref_clk(ref_clk), .nrst(nrst), .port_wr(port_wr), .chan_wr(chan_wr),
   .pad_oe_n_q(pad_oe_n_q), .gpio_fn_q(gpio_fn_q), .gpio_dir_q(gpio_dir_q), .gpio_data_q(gpio_data_q),
   .gpio_inen_q(gpio_inen_q), .gpio_pin_q(gpio_pin_q), .chan_st_q(chan_st_q), .pin_irq_channel_0(pin_irq_channel_0));
`default_nettype wire

// ===== verification/pmgpi_top_tb.sv
// Self-checking bench for the pin mux, GPIO and pin interrupt top.
// Assumes the board model feeds the pads and the checker is bound in.
`timescale 1ns/1ps
`default_nettype none
module pmgpi_top_tb;
   import pmgpi_pkg::*;
   logic                                             ref_clk = 1'b0;
   logic                                             nrst = 1'b0;
   pmgpi_port_wr_s [NUM_PORTS-1:0]                   port_wr = '0;
   pmgpi_chan_wr_s [NUM_CHAN-1:0]                    chan_wr = '0;
   logic [NUM_PORTS-1:0][PORT_PINS-1:0][NUM_FUNC-1:0] periph_o = '0;
   logic [NUM_PORTS-1:0][PORT_PINS-1:0][NUM_FUNC-1:0] periph_oe = '0;
   logic [NUM_PORTS-1:0][PORT_PINS-1:0]              ext_lvl = '0;
   wire logic [NUM_PORTS-1:0][PORT_PINS-1:0]         pad_in, pad_out_q, pad_oe_n_q, fn_q, dir_q, data_q, inen_q, pin_q;
   wire logic [NUM_PORTS-1:0][PORT_PINS-1:0]         periph_in_q;
   wire logic [NUM_PORTS-1:0][MUX_W-1:0]             mux_q;
   wire pmgpi_chan_st_s [NUM_CHAN-1:0]               st_q;
   wire logic [3:0]                                  irq;
   int                                               n_errors = 0;
   int                                               checks = 0;
   int                                               cyc = 0;
   // ----------------------------------------------------------------
   // Design, pads and clock
   // ----------------------------------------------------------------
   pmgpi_top u_dut (.ref_clk(ref_clk), .nrst(nrst), .port_wr(port_wr), .periph_o(periph_o), .periph_oe(periph_oe),
      .pad_in(pad_in), .chan_wr(chan_wr), .pad_out_q(pad_out_q), .pad_oe_n_q(pad_oe_n_q), .periph_in_q(periph_in_q),
      .gpio_fn_q(fn_q), .gpio_dir_q(dir_q), .gpio_data_q(data_q), .gpio_inen_q(inen_q), .gpio_pin_q(pin_q),
      .gpio_mux_q(mux_q), .chan_st_q(st_q), .pin_irq_channel_0(irq[0]), .pin_irq_channel_1(irq[1]),
      .pin_irq_channel_2(irq[2]), .pin_irq_channel_3(irq[3]));
   pmgpi_board u_board (.pad_drv(pad_out_q), .pad_oe_n(pad_oe_n_q), .ext_lvl(ext_lvl), .pad_lvl(pad_in));
   // Free-running 100 MHz clock.
   initial begin
      forever #5 ref_clk = ~ref_clk;
   end
   // Hang guard; the whole run needs well under a thousand cycles.
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 3000) begin
         n_errors++;
         final_report();
      end
   end
   // ----------------------------------------------------------------
   // Shared tasks
   // ----------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task automatic settle(input int n);
      repeat (n) @(posedge ref_clk);
      @(negedge ref_clk);
   endtask : settle
   // One-cycle strobes; results are sampled half a cycle after the taking edge.
   task automatic pwr(input int p, input pmgpi_port_wr_s w);
      @(posedge ref_clk);
      port_wr[p] <= w;
      @(posedge ref_clk);
      port_wr[p] <= '0;
      @(negedge ref_clk);
   endtask : pwr
   task automatic cwr(input int c, input pmgpi_chan_wr_s w);
      @(posedge ref_clk);
      chan_wr[c] <= w;
      @(posedge ref_clk);
      chan_wr[c] <= '0;
      @(negedge ref_clk);
   endtask : cwr
   task automatic final_report();
      $display("checks=%0d n_errors=%0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : final_report
   // ----------------------------------------------------------------
   // Scenarios
   // ----------------------------------------------------------------
   task automatic do_reset();
      @(posedge ref_clk);
      nrst <= 1'b0;
      settle(4);
      for (int p = 0; p < NUM_PORTS; p++) begin
         chk(fn_q[p] | dir_q[p] | data_q[p] | inen_q[p] | pin_q[p] | pad_out_q[p] | periph_in_q[p], 32'h0);
         chk(pad_oe_n_q[p], 32'h0000FFFF);
         chk(mux_q[p], 32'h0);
      end
      for (int c = 0; c < NUM_CHAN; c++) begin
         chk(st_q[c].mask | st_q[c].latch | st_q[c].assign_sel | st_q[c].edge_mode | st_q[c].inv, 32'h0);
      end
      chk(irq, 32'h0);
      @(posedge ref_clk);
      nrst <= 1'b1;
      @(negedge ref_clk);
   endtask : do_reset
   // Every port gets its own pattern; set beats clear on a shared bit.
   task automatic s_setclr();
      pmgpi_port_wr_s w;
      for (int p = 0; p < NUM_PORTS; p++) begin
         w = '0;
         w.data_set = 16'hA5A5 ^ 16'(p);
         pwr(p, w);
         w = '0;
         w.data_clr = 16'h01FF;
         w.data_set = 16'h0100;
         pwr(p, w);
      end
      settle(1);
      for (int p = 0; p < NUM_PORTS; p++) begin
         chk(data_q[p], ((16'hA5A5 ^ 16'(p)) & 16'hFE00) | 16'h0100);
         chk(dir_q[p] | pad_out_q[p], 32'h0);
      end
   endtask : s_setclr
   task automatic s_gpio_in();
      pmgpi_port_wr_s w;
      @(posedge ref_clk);
      ext_lvl[0][8] <= 1'b1;
      settle(4);
      chk(pin_q[0][8], 32'h0);
      w = '0;
      w.inen_set = 16'h0100;
      pwr(0, w);
      settle(3);
      chk(pin_q[0][8], 32'h1);
      w = '0;
      w.inen_clr = 16'h0100;
      pwr(0, w);
      @(posedge ref_clk);
      ext_lvl[0][8] <= 1'b0;
      settle(4);
      chk(pin_q[0][8], 32'h0);
   endtask : s_gpio_in
   // Channel c takes the high half of port c; channel 0 sees its own GPIO output.
   task automatic s_irq_edge();
      pmgpi_chan_wr_s cw;
      pmgpi_port_wr_s w;
      int b;
      for (int c = 0; c < NUM_CHAN; c++) begin
         b = 9 * c;
         cw = '0;
         cw.assign_wr = 1'b1;
         cw.assign_data = 32'(2 * c + 1) << (8 * c);
         cw.edge_set = 32'h1 << b;
         cw.mask_set = 32'h1 << b;
         cwr(c, cw);
         chk(st_q[c].assign_sel, 32'(2 * c + 1) << (8 * c));
         w = '0;
         w.dir_set = 16'h0100;
         if (c == 0) begin
            pwr(0, w);
         end else begin
            @(posedge ref_clk);
            ext_lvl[c][8+c] <= 1'b1;
         end
         settle(6);
         chk({st_q[c].pins[b], st_q[c].latch[b], irq[c]}, 32'h7);
         w = '0;
         w.dir_clr = 16'h0100;
         if (c == 0) begin
            pwr(0, w);
         end else begin
            @(posedge ref_clk);
            ext_lvl[c][8+c] <= 1'b0;
         end
         settle(6);
         chk({st_q[c].pins[b], st_q[c].latch[b], irq}, 32'h10 | (32'h1 << c));
         cw = '0;
         cw.mask_clr = 32'h1 << b;
         cwr(c, cw);
         settle(1);
         chk({st_q[c].latch[b], irq[c]}, 32'h2);
         cw = '0;
         cw.latch_clr = 32'h1 << b;
         cwr(c, cw);
         chk(st_q[c].latch[b], 32'h0);
      end
   endtask : s_irq_edge
   // Active-low level on channel 1, then falling-edge mode with the same polarity.
   task automatic s_level();
      pmgpi_chan_wr_s cw;
      cw = '0;
      cw.edge_clr = 32'h200;
      cw.inv_set = 32'h200;
      cw.mask_set = 32'h200;
      cwr(1, cw);
      settle(6);
      chk({st_q[1].latch[9], irq[1]}, 32'h3);
      cw = '0;
      cw.latch_clr = 32'h200;
      cwr(1, cw);
      settle(1);
      chk(st_q[1].latch[9], 32'h1);
      @(posedge ref_clk);
      ext_lvl[1][9] <= 1'b1;
      settle(6);
      chk({st_q[1].latch[9], irq[1]}, 32'h0);
      cw = '0;
      cw.edge_set = 32'h200;
      cwr(1, cw);
      @(posedge ref_clk);
      ext_lvl[1][9] <= 1'b0;
      settle(6);
      chk({st_q[1].latch[9], irq[1]}, 32'h3);
   endtask : s_level
   // Peripheral takes a pin through select 2, then reset hands it back to GPIO.
   task automatic s_mux();
      pmgpi_port_wr_s w;
      @(posedge ref_clk);
      periph_o[2][5] <= 4'h4;
      periph_oe[2][5] <= 4'h4;
      w = '0;
      w.fn_set = 16'h0020;
      w.inen_set = 16'h0020;
      w.mux_wr = 1'b1;
      w.mux_data = 32'h00000800;
      pwr(2, w);
      settle(1);
      chk({fn_q[3], fn_q[2]}, 32'h00000020);
      chk(mux_q[2], 32'h00000800);
      chk({pad_out_q[2][5], pad_oe_n_q[2][5]}, 32'h2);
      settle(3);
      chk({periph_in_q[2][5], pin_q[2][5]}, 32'h2);
      do_reset();
   endtask : s_mux
   // Main sequence.
   initial begin
      do_reset();
      s_setclr();
      s_gpio_in();
      s_irq_edge();
      s_level();
      s_mux();
      final_report();
   end
endmodule : pmgpi_top_tb
`default_nettype wire
